// ==== dv/ckn_clock_control_assertions.sv ====
`timescale 1ns/100ps
module ckn_clock_control_chk
    import ckn_pkg::*;
#(
    parameter int NUM_LINES = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic pll_enable,
    input wire logic pll_areset,
    input wire logic pfd_enable,
    input wire logic [NUM_LINES-1:0] line_enable,
    input wire logic [NUM_LINES-1:0] global_clock_line_q,
    input wire logic [CKN_BUS_W-1:0] column_io_clock_q,
    input wire logic [CKN_BUS_W-1:0] row_clock_q,
    input wire logic [CKN_BUS_W-1:0] row_io_clock_q,
    input wire logic [CKN_CLUSTER_W-1:0] cluster_clock_q,
    input wire logic [2:0] pll_clock_q,
    input wire logic ext_clock_pin_q,
    input wire logic pfd_up_q,
    input wire logic pfd_down_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Allow for input sampling plus counter clearing
    sequence s_off;
        (ce && !(pll_enable && !pll_areset)) [*4];
    endsequence
    sequence s_areset;
        (ce && pll_areset) [*4];
    endsequence
    sequence s_nogate;
        (ce && !pfd_enable) [*3];
    endsequence
    a_line_off: assert property ($past(ce) |->
        (global_clock_line_q & ~$past(line_enable)) == '0)
        else $error("disabled line still runs");
    a_row_io: assert property ($past(ce) |->
        row_io_clock_q == $past(row_clock_q))
        else $error("row io bus not one cycle behind");
    a_cluster_src: assert property ($past(ce) && cluster_clock_q != '0
        |-> $past(row_clock_q) != '0)
        else $error("cluster clock without row clock");
    a_column_src: assert property ($past(ce) && column_io_clock_q != '0
        |-> $past(global_clock_line_q) != '0)
        else $error("column bus without global line");
    a_ext_from_third: assert property (ext_clock_pin_q |->
        pll_clock_q[2] || $past(pll_clock_q[2]))
        else $error("pin clock without third output");
    a_off_quiet: assert property (s_off |->
        pll_clock_q == 3'h0 && !ext_clock_pin_q)
        else $error("loop outputs while not running");
    a_reset_quiet: assert property (s_areset |->
        !pfd_up_q && !pfd_down_q)
        else $error("detector active in reset");
    a_gate_quiet: assert property (s_nogate |->
        !pfd_up_q && !pfd_down_q)
        else $error("detector pulse while gated");
endmodule : ckn_clock_control_chk
bind ckn_clock_control ckn_clock_control_chk #(.NUM_LINES(NUM_LINES))
    u_chk (.*);

// ==== dv/ckn_fabric_model.sv ====
`timescale 1ns/100ps
module ckn_fabric_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    output logic ref_clock_a,
    output logic ref_clock_b,
    output logic vco_step,
    output logic raw_lock
);
    logic [1:0] cnt_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 2'h0;
            ref_clock_a <= 1'b0;
            ref_clock_b <= 1'b0;
            vco_step <= 1'b0;
            raw_lock <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            // Two references of different rate for switchover
            ref_clock_a <= ~ref_clock_a;
            ref_clock_b <= cnt_q[1];
            // Slow mode halves the step rate
            vco_step <= ~slow | cnt_q[0];
            raw_lock <= 1'b1;
        end
    end
endmodule : ckn_fabric_model

// ==== dv/test_clock_network_pll_control.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %0t %h %h", $time, g, e); end end
module test_clock_network_pll_control;
    import ckn_pkg::*;
    logic clk, reset, ce, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, feedback_mode_q, cluster_clock_q;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, ext_clock_pin_q;
    logic [31:0] clock_pin, global_source_choice;
    logic [15:0] dual_use_clock_pin, internal_clock, line_enable;
    logic [15:0] global_clock_line_q;
    logic ref_clock_a, ref_clock_b, reference_choice, pll_enable;
    logic pll_areset, pfd_enable, vco_step, raw_lock, pll_ref_clock_q;
    logic [5:0] column_io_clock_q, row_clock_q, row_io_clock_q;
    logic [2:0] pll_clock_q;
    logic pfd_up_q, pfd_down_q, lock_to_fabric_q, lock_to_pin_q, irq_q;
    int n_fail = 0;
    int n_checks = 0;
    ckn_clock_control DUT (.*);
    ckn_fabric_model fab (.*);
    task automatic summarize;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= {24'h00_0000, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= {24'h00_0000, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata & m, e)
        `CHK(s_axi_rresp, er)
    endtask : rc
    task automatic t_regs;
        rc(CKN_LOCKCNT_OFS, 32'hFFFF_FFFF, CKN_LOCKCNT_RST, 2'b00);
        rc(CKN_CTRL_OFS, 32'hFFFF_FFFF, CKN_CTRL_RST, 2'b00);
        rc(8'h40, 32'h0000_0000, 32'h0000_0000, CKN_RESP_SLVERR);
        wr(CKN_MULT_OFS, 32'h0000_031F);
        rc(CKN_MULT_OFS, 32'hFFFF_FFFF, 32'h0000_031F, 2'b00);
    endtask : t_regs
    task automatic t_lines;
        wr(CKN_ROWSEL_OFS, 32'h00FF_FFF1);
        wr(CKN_COLSEL_OFS, 32'h001F_FFFF);
        wr(CKN_CLUSEL_OFS, 32'h0000_0060);
        clock_pin <= 32'h0000_0004;
        repeat (5) @(posedge clk);
        `CHK(global_clock_line_q[1:0], 2'b10)
        `CHK(row_clock_q, 6'h01)
        `CHK(column_io_clock_q, 6'h20)
        `CHK(row_io_clock_q, 6'h01)
        `CHK(cluster_clock_q, 2'b01)
        global_source_choice[3:2] <= 2'b01;
        repeat (2) @(posedge clk);
        `CHK(global_clock_line_q[1], 1'b0)
        global_source_choice[3:2] <= 2'b00;
        line_enable[1] <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(global_clock_line_q[1], 1'b0)
        line_enable[1] <= 1'b1;
        clock_pin <= 32'h0000_0000;
        internal_clock[1] <= 1'b1;
        wr(CKN_STATSEL_OFS, 32'h0002_0002);
        repeat (2) @(posedge clk);
        `CHK(global_clock_line_q[1], 1'b1)
        wr(CKN_STATSEL_OFS, 32'h0000_0000);
    endtask : t_lines
    task automatic t_pll;
        int c[4];
        wr(CKN_POST0_OFS, 32'h0000_0001);
        wr(CKN_POST1_OFS, 32'h0003_0003);
        wr(CKN_POST2_OFS, 32'h0000_0103);
        wr(CKN_CTRL_OFS, 32'h0000_0020);
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            c = '{0, 0, 0, 0};
            repeat (40) @(posedge clk);
            // Window spans whole periods, so phase does not matter
            repeat (64 << s) begin
                @(posedge clk);
                c[0] += pll_clock_q[0];
                c[1] += pll_clock_q[1];
                c[2] += pll_clock_q[2];
                c[3] += ext_clock_pin_q;
            end
            `CHK(c[0], 32 << s)
            `CHK(c[1], 16 << s)
            `CHK(c[2], 32 << s)
            `CHK(c[3], 32 << s)
        end
        slow <= 1'b0;
    endtask : t_pll
    task automatic t_lock;
        int n;
        wr(CKN_LOCKCNT_OFS, 32'h0000_0008);
        wr(CKN_CTRL_OFS, 32'h0000_001C);
        pll_areset <= 1'b1;
        repeat (5) @(posedge clk);
        pll_areset <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(lock_to_fabric_q, 1'b0)
        n = 3;
        while (lock_to_fabric_q !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        `CHK(n inside {[8:12]}, 1'b1)
        `CHK(lock_to_pin_q, 1'b1)
        `CHK(irq_q, 1'b0)
        wr(CKN_IRQMSK_OFS, 32'h0000_0001);
        repeat (2) @(posedge clk);
        `CHK(irq_q, 1'b1)
        rc(CKN_IRQST_OFS, 32'h0000_0001, 32'h0000_0001, 2'b00);
        repeat (2) @(posedge clk);
        `CHK(irq_q, 1'b0)
        pll_enable <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(lock_to_fabric_q, 1'b0)
        `CHK(pll_clock_q, 3'h0)
        pll_enable <= 1'b1;
    endtask : t_lock
    task automatic t_ref;
        int n;
        wr(CKN_CTRL_OFS, 32'h0000_0002);
        reference_choice <= 1'b1;
        repeat (3) @(posedge clk);
        rc(CKN_STATE_OFS, 32'h0000_0004, 32'h0000_0004, 2'b00);
        rc(CKN_IRQST_OFS, 32'h0000_0004, 32'h0000_0004, 2'b00);
        reference_choice <= 1'b0;
        wr(CKN_CTRL_OFS, 32'h0000_0001);
        rc(CKN_STATE_OFS, 32'h0000_0004, 32'h0000_0004, 2'b00);
        for (int k = 0; k < 3; k++) begin
            wr(CKN_CTRL_OFS, {24'h00_0000, k[1:0], 6'h00});
            repeat (2) @(posedge clk);
            `CHK(feedback_mode_q, k[1:0])
        end
        pfd_enable <= 1'b0;
        repeat (4) @(posedge clk);
        n = 0;
        repeat (40) begin
            @(posedge clk);
            n += pfd_up_q;
        end
        `CHK(n, 0)
        pfd_enable <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            n += pfd_up_q;
        end
        `CHK(n > 0, 1'b1)
    endtask : t_ref
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {reset, ce, slow, reference_choice} = 4'b1100;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        {clock_pin, global_source_choice} = '0;
        {dual_use_clock_pin, internal_clock} = '0;
        line_enable = 16'hFFFF;
        {pll_enable, pll_areset, pfd_enable} = 3'b101;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_regs();
        t_lines();
        t_pll();
        t_lock();
        t_ref();
        summarize();
    end
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
endmodule : test_clock_network_pll_control

// ==== src/ckn_clock_control.sv ====
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// - Sixteen global lines multiplexed onto six-line buses
// - Cluster selector picks two of six row lines
// - Row lines also feed row I/O region
// - Each I/O region gets at most six lines
// - Output equals input times m over n times post
// - Phase offset in eighth-of-oscillator-period steps
// - Independent duty cycle on each post divider
// - Outputs drive global lines; third also external pin
// - Manual switch between two reference clocks
// - Lock held low for chosen reference transitions
// - Gated or ungated lock routed to fabric or pin
// - Three selectable feedback modes
// - Enable input turns loop on and off
// - Reset input resets and resynchronises loop
// - Detector gate input gates detector output
// - Dynamic choice of two pins, two loop outputs
// - Each global line enabled or disabled at runtime
// - Reference selector static or dynamic, drives loop
module ckn_clock_control
    import ckn_pkg::*;
#(
    parameter int NUM_LINES = 16,
    parameter int LOCK_CNT_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2*NUM_LINES-1:0] clock_pin,
    input wire logic [NUM_LINES-1:0] dual_use_clock_pin,
    input wire logic [NUM_LINES-1:0] internal_clock,
    input wire logic [2*NUM_LINES-1:0] global_source_choice,
    input wire logic [NUM_LINES-1:0] line_enable,
    input wire logic ref_clock_a,
    input wire logic ref_clock_b,
    input wire logic reference_choice,
    input wire logic pll_enable,
    input wire logic pll_areset,
    input wire logic pfd_enable,
    input wire logic vco_step,
    input wire logic raw_lock,
    output logic [NUM_LINES-1:0] global_clock_line_q,
    output logic [CKN_BUS_W-1:0] column_io_clock_q,
    output logic [CKN_BUS_W-1:0] row_clock_q,
    output logic [CKN_BUS_W-1:0] row_io_clock_q,
    output logic [CKN_CLUSTER_W-1:0] cluster_clock_q,
    output logic [2:0] pll_clock_q,
    output logic ext_clock_pin_q,
    output logic pll_ref_clock_q,
    output logic pfd_up_q,
    output logic pfd_down_q,
    output logic [1:0] feedback_mode_q,
    output logic lock_to_fabric_q,
    output logic lock_to_pin_q,
    output logic irq_q
);
    function automatic logic [8:0] steps_of(input logic [4:0] f);
        steps_of = {1'b0, f, 3'b000} + 9'h008;
    endfunction : steps_of
    // Phase offset delays the first edge, clamped inside one period
    function automatic logic [8:0] start_of(input logic [4:0] f,
                                            input logic [7:0] ph);
        logic [8:0] p;
        p = ({1'b0, ph} >= steps_of(f)) ? steps_of(f) - 9'h001 : {1'b0, ph};
        start_of = (p == 9'h000) ? 9'h000 : steps_of(f) - p;
    endfunction : start_of
    function automatic logic mapped(input logic [31:0] a);
        mapped = (a[31:8] == 24'h00_0000) && (a[1:0] == 2'b00)
                 && (a[7:0] <= CKN_STATE_OFS);
    endfunction : mapped
    logic [31:0] ctrl_q, mult_q, lockcnt_q;
    logic [31:0] post_q [3];
    logic [31:0] statsel_q, colsel_q, rowsel_q, clusel_q;
    logic [CKN_NUM_EV-1:0] status_q, mask_q;
    logic wr_go, rd_go, status_read;
    logic [31:0] wmask, state_word, rd_word;
    assign wr_go = s_axi_awvalid && s_axi_wvalid && s_axi_awready
                   && s_axi_wready;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign status_read = rd_go && (s_axi_araddr[7:0] == CKN_IRQST_OFS)
                         && mapped(s_axi_araddr);
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    // Both channels are taken together; ready pulses for one cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CKN_RESP_OKAY;
        end else if (ce) begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                             && !s_axi_bvalid;
            s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                            && !s_axi_bvalid;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(s_axi_awaddr) ? CKN_RESP_OKAY
                                                    : CKN_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= CKN_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= mapped(s_axi_araddr) ? CKN_RESP_OKAY
                                                    : CKN_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    always_comb begin
        rd_word = 32'h0000_0000;
        if (mapped(s_axi_araddr)) begin
            unique case (s_axi_araddr[7:0])
                CKN_CTRL_OFS: rd_word = ctrl_q;
                CKN_MULT_OFS: rd_word = mult_q;
                CKN_POST0_OFS: rd_word = post_q[0];
                CKN_POST1_OFS: rd_word = post_q[1];
                CKN_POST2_OFS: rd_word = post_q[2];
                CKN_LOCKCNT_OFS: rd_word = lockcnt_q;
                CKN_STATSEL_OFS: rd_word = statsel_q;
                CKN_COLSEL_OFS: rd_word = colsel_q;
                CKN_ROWSEL_OFS: rd_word = rowsel_q;
                CKN_CLUSEL_OFS: rd_word = clusel_q;
                CKN_IRQST_OFS: rd_word = {29'h0, status_q};
                CKN_IRQMSK_OFS: rd_word = {29'h0, mask_q};
                CKN_STATE_OFS: rd_word = state_word;
            endcase
        end
    end
    function automatic logic [31:0] upd(input logic [31:0] old);
        upd = (old & ~wmask) | (s_axi_wdata & wmask);
    endfunction : upd
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= CKN_CTRL_RST;
            mult_q <= CKN_MULT_RST;
            post_q <= '{default: CKN_POST_RST};
            lockcnt_q <= CKN_LOCKCNT_RST;
            statsel_q <= CKN_SEL_RST;
            colsel_q <= CKN_SEL_RST;
            rowsel_q <= CKN_SEL_RST;
            clusel_q <= CKN_SEL_RST;
            mask_q <= '0;
        end else if (ce && wr_go && mapped(s_axi_awaddr)) begin
            unique case (s_axi_awaddr[7:0])
                CKN_CTRL_OFS: ctrl_q <= upd(ctrl_q);
                CKN_MULT_OFS: mult_q <= upd(mult_q);
                CKN_POST0_OFS: post_q[0] <= upd(post_q[0]);
                CKN_POST1_OFS: post_q[1] <= upd(post_q[1]);
                CKN_POST2_OFS: post_q[2] <= upd(post_q[2]);
                CKN_LOCKCNT_OFS: lockcnt_q <= upd(lockcnt_q);
                CKN_STATSEL_OFS: statsel_q <= upd(statsel_q);
                CKN_COLSEL_OFS: colsel_q <= upd(colsel_q);
                CKN_ROWSEL_OFS: rowsel_q <= upd(rowsel_q);
                CKN_CLUSEL_OFS: clusel_q <= upd(clusel_q);
                CKN_IRQMSK_OFS: if (s_axi_wstrb[0]) begin
                    mask_q <= s_axi_wdata[CKN_NUM_EV-1:0];
                end
                default: ;
            endcase
        end
    end
    logic run, run_q, ref_sel, ref_sel_q;
    logic ref_now, ref_prev_q, ref_rise, ref_edge;
    assign run = pll_enable && !pll_areset;
    assign ref_sel = ctrl_q[CKN_CTRL_MANUAL_BIT] ? reference_choice
                     : ctrl_q[CKN_CTRL_REFSTAT_BIT];
    assign ref_now = ref_sel ? ref_clock_b : ref_clock_a;
    assign ref_rise = ref_now && !ref_prev_q;
    assign ref_edge = ref_now != ref_prev_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_q <= 1'b0;
            ref_sel_q <= 1'b0;
            ref_prev_q <= 1'b0;
            pll_ref_clock_q <= 1'b0;
            feedback_mode_q <= CKN_FB_ZERO_DELAY;
        end else if (ce) begin
            run_q <= run;
            ref_sel_q <= ref_sel;
            ref_prev_q <= ref_now;
            pll_ref_clock_q <= ref_now;
            feedback_mode_q <= ctrl_q[CKN_CTRL_FBMODE_LSB +: 2];
        end
    end
    logic [1:0] n_cnt_q;
    logic [2:0] step_q;
    logic [4:0] m_cnt_q;
    logic ref_div_ev, fb_ev;
    assign ref_div_ev = ref_rise && (n_cnt_q == mult_q[CKN_MULT_N_LSB +: 2]);
    assign fb_ev = vco_step && (step_q == CKN_LAST_STEP)
                   && (m_cnt_q == mult_q[CKN_MULT_M_LSB +: 5]);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            n_cnt_q <= 2'b00;
            step_q <= 3'h0;
            m_cnt_q <= 5'h00;
            pfd_up_q <= 1'b0;
            pfd_down_q <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                n_cnt_q <= 2'b00;
                step_q <= 3'h0;
                m_cnt_q <= 5'h00;
            end else begin
                if (ref_rise) begin
                    n_cnt_q <= ref_div_ev ? 2'b00 : n_cnt_q + 2'b01;
                end
                if (vco_step) begin
                    step_q <= step_q + 3'h1;
                    if (step_q == CKN_LAST_STEP) begin
                        m_cnt_q <= fb_ev ? 5'h00 : m_cnt_q + 5'h01;
                    end
                end
            end
            pfd_up_q <= run && pfd_enable && ref_div_ev;
            pfd_down_q <= run && pfd_enable && fb_ev;
        end
    end
    logic [8:0] post_cnt_q [3];
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            post_cnt_q <= '{default: 9'h000};
            pll_clock_q <= 3'b000;
            ext_clock_pin_q <= 1'b0;
        end else if (ce) begin
            for (int k = 0; k < 3; k++) begin
                if (!run) begin
                    post_cnt_q[k] <= start_of(post_q[k][CKN_POST_C_LSB +: 5],
                        post_q[k][CKN_POST_PH_LSB +: 8]);
                    pll_clock_q[k] <= 1'b0;
                end else if (vco_step) begin
                    if (post_cnt_q[k] + 9'h001
                        >= steps_of(post_q[k][CKN_POST_C_LSB +: 5])) begin
                        post_cnt_q[k] <= 9'h000;
                    end else begin
                        post_cnt_q[k] <= post_cnt_q[k] + 9'h001;
                    end
                    pll_clock_q[k] <= post_cnt_q[k]
                        < steps_of(post_q[k][CKN_POST_H_LSB +: 5]);
                end
            end
            ext_clock_pin_q <= ctrl_q[CKN_CTRL_EXTEN_BIT]
                               && pll_clock_q[2];
        end
    end
    // Lock gating: count reference transitions before lock may show
    logic [LOCK_CNT_W-1:0] trans_q;
    logic gated_lock, lock_sel, lock_sel_q;
    assign gated_lock = raw_lock && run_q
                        && (trans_q >= lockcnt_q[LOCK_CNT_W-1:0]);
    assign lock_sel = ctrl_q[CKN_CTRL_GATED_BIT] ? gated_lock
                      : raw_lock && run_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trans_q <= '0;
        end else if (ce) begin
            if (!run) begin
                trans_q <= '0;
            end else if (ref_edge && trans_q != '1) begin
                trans_q <= trans_q + 1'b1;
            end
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lock_sel_q <= 1'b0;
            lock_to_fabric_q <= 1'b0;
            lock_to_pin_q <= 1'b0;
        end else if (ce) begin
            lock_sel_q <= lock_sel;
            lock_to_fabric_q <= lock_sel && ctrl_q[CKN_CTRL_LKFAB_BIT];
            lock_to_pin_q <= lock_sel && ctrl_q[CKN_CTRL_LKPIN_BIT];
        end
    end
    // Sticky events; a new event beats the read that clears it
    logic [CKN_NUM_EV-1:0] ev, status_d;
    assign ev = {ref_sel != ref_sel_q, !lock_sel && lock_sel_q,
                 lock_sel && !lock_sel_q};
    assign status_d = (status_read ? '0 : status_q) | ev;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_q <= '0;
            irq_q <= 1'b0;
        end else if (ce) begin
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
        end
    end
    assign state_word = {{(32-LOCK_CNT_W){1'b0}}, trans_q} << 16
                        | {28'h000_0000, run_q, ref_sel_q, gated_lock,
                           raw_lock};
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            global_clock_line_q <= '0;
        end else if (ce) begin
            for (int i = 0; i < NUM_LINES; i++) begin
                logic src;
                if (statsel_q[i % 16]) begin
                    src = statsel_q[16 + (i % 16)] ? internal_clock[i]
                          : dual_use_clock_pin[i];
                end else begin
                    unique case (global_source_choice[2*i +: 2])
                        2'b00: src = clock_pin[2*i];
                        2'b01: src = clock_pin[2*i+1];
                        2'b10: src = pll_clock_q[i % 3];
                        2'b11: src = pll_clock_q[(i + 1) % 3];
                    endcase
                end
                global_clock_line_q[i] <= line_enable[i] && src;
            end
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            column_io_clock_q <= '0;
            row_clock_q <= '0;
            row_io_clock_q <= '0;
            cluster_clock_q <= '0;
        end else if (ce) begin
            for (int b = 0; b < CKN_BUS_W; b++) begin
                column_io_clock_q[b] <=
                    global_clock_line_q[colsel_q[4*b +: 4]];
                row_clock_q[b] <=
                    global_clock_line_q[rowsel_q[4*b +: 4]];
                row_io_clock_q[b] <= row_clock_q[b];
            end
            for (int c = 0; c < CKN_CLUSTER_W; c++) begin
                // Out-of-range pick reads as a quiet line
                cluster_clock_q[c] <= (clusel_q[4*c +: 3] < 3'd6)
                    && row_clock_q[clusel_q[4*c +: 3]];
            end
        end
    end
endmodule : ckn_clock_control

// ==== src/ckn_pkg.sv ====
package ckn_pkg;
    // Register byte offsets
    localparam logic [7:0] CKN_CTRL_OFS = 8'h00;
    localparam logic [7:0] CKN_MULT_OFS = 8'h04;
    localparam logic [7:0] CKN_POST0_OFS = 8'h08;
    localparam logic [7:0] CKN_POST1_OFS = 8'h0C;
    localparam logic [7:0] CKN_POST2_OFS = 8'h10;
    localparam logic [7:0] CKN_LOCKCNT_OFS = 8'h14;
    localparam logic [7:0] CKN_STATSEL_OFS = 8'h18;
    localparam logic [7:0] CKN_COLSEL_OFS = 8'h1C;
    localparam logic [7:0] CKN_ROWSEL_OFS = 8'h20;
    localparam logic [7:0] CKN_CLUSEL_OFS = 8'h24;
    localparam logic [7:0] CKN_IRQST_OFS = 8'h28;
    localparam logic [7:0] CKN_IRQMSK_OFS = 8'h2C;
    localparam logic [7:0] CKN_STATE_OFS = 8'h30;
    // Control register fields
    localparam int CKN_CTRL_REFSTAT_BIT = 0;
    localparam int CKN_CTRL_MANUAL_BIT = 1;
    localparam int CKN_CTRL_GATED_BIT = 2;
    localparam int CKN_CTRL_LKFAB_BIT = 3;
    localparam int CKN_CTRL_LKPIN_BIT = 4;
    localparam int CKN_CTRL_EXTEN_BIT = 5;
    localparam int CKN_CTRL_FBMODE_LSB = 6;
    // Multiply register: m-1 and n-1
    localparam int CKN_MULT_M_LSB = 0;
    localparam int CKN_MULT_N_LSB = 8;
    // Post divider register: count-1, high time-1, phase steps
    localparam int CKN_POST_C_LSB = 0;
    localparam int CKN_POST_H_LSB = 8;
    localparam int CKN_POST_PH_LSB = 16;
    // Status and mask bits
    localparam int CKN_EV_LOCK_RISE = 0;
    localparam int CKN_EV_LOCK_FALL = 1;
    localparam int CKN_EV_REF_SWAP = 2;
    localparam int CKN_NUM_EV = 3;
    // Reset values
    localparam logic [31:0] CKN_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CKN_MULT_RST = 32'h0000_0000;
    localparam logic [31:0] CKN_POST_RST = 32'h0000_0000;
    localparam logic [31:0] CKN_LOCKCNT_RST = 32'h0000_0010;
    localparam logic [31:0] CKN_SEL_RST = 32'h0000_0000;
    // Phase steps per oscillator period
    localparam int CKN_STEPS_PER_VCO = 8;
    localparam logic [2:0] CKN_LAST_STEP = 3'h7;
    // Number of lines on a region bus and per cluster
    localparam int CKN_BUS_W = 6;
    localparam int CKN_CLUSTER_W = 2;
    // Feedback modes
    typedef enum logic [1:0] {
        CKN_FB_ZERO_DELAY = 2'b00,
        CKN_FB_NORMAL = 2'b01,
        CKN_FB_NONE = 2'b10
    } ckn_fb_mode_t;
    // AXI responses
    localparam logic [1:0] CKN_RESP_OKAY = 2'b00;
    localparam logic [1:0] CKN_RESP_SLVERR = 2'b10;
endpackage : ckn_pkg
